/* File: rtl/scdc_fifo.sv */
// scdc_fifo: synchronous fifo with valid/ready on both sides.
// assumes: one clock; depth is a power of two.
`timescale 1ns/1ps
`default_nettype none
module scdc_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 32
) (
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr;
	logic [AW:0]      rd_ptr;
	logic             push;
	logic             pop;

	assign out_valid = wr_ptr != rd_ptr;
	assign in_ready  = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rd_ptr[AW-1:0]];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end
endmodule : scdc_fifo
`default_nettype wire

/* File: rtl/scdc_pkg.sv */
// scdc_pkg: constants, states and helpers of the serial chain loader.
// assumes: a 40 MHz system clock; the bench runs the link clock at 200 ns.
`default_nettype none
package scdc_pkg;

	localparam int CLK_PERIOD_NS  = 25;
	localparam int LINK_PERIOD_NS = 200;
	// longest half period, rounded down, never below one cycle
	localparam int LINK_HALF_RAW  = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam int LINK_HALF_CYC  = (LINK_HALF_RAW < 1) ? 1 : LINK_HALF_RAW;

	localparam logic [31:0] PASS_LIMIT_NEW = 32'hffff_ffe0;
	localparam logic [31:0] PASS_LIMIT_OLD = 32'h01ff_ff28;

	localparam int HDR_BITS = 32;
	localparam int CRC_BITS = 16;
	localparam int OWN_BITS_DEFAULT = 1024;

	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] CRC_INIT = 16'hffff;

	localparam int FIFO_DEPTH = 32;

	typedef enum logic [2:0] {
		ST_HEADER,
		ST_PASS,
		ST_OWN,
		ST_CHECK,
		ST_OUTREL,
		ST_RELEASE,
		ST_DONE,
		ST_ERROR
	} scdc_state_e;

	function automatic logic [15:0] scdc_crc_step(
		input logic [15:0] crc,
		input logic        bit_in
	);
		logic fb;
		fb = crc[15] ^ bit_in;
		scdc_crc_step = {crc[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
	endfunction : scdc_crc_step

endpackage : scdc_pkg
`default_nettype wire

/* File: rtl/scdc_sync.sv */
// scdc_sync: two-flop synchroniser for a group of pins, with edge pulses.
// assumes: inputs are asynchronous to clk; edges are taken after stage two.
`timescale 1ns/1ps
`default_nettype none
module scdc_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic [WIDTH-1:0] pin,
	output logic      [WIDTH-1:0] level,
	output logic      [WIDTH-1:0] rise,
	output logic      [WIDTH-1:0] fall
);
	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] last;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			meta  <= '0;
			level <= '0;
			last  <= '0;
		end else begin
			meta  <= pin;
			level <= meta;
			last  <= level;
		end
	end

	assign rise = level & ~last;
	assign fall = ~level & last;
endmodule : scdc_sync
`default_nettype wire

/* File: rtl/scdc_top.sv */
// scdc_top: serial daisy-chain loader of one chained device.
// assumes: pins are asynchronous; the completion pin is open-drain except on the first device with active drive, pulled up
// outside; straps are steady while the chain loads.
`timescale 1ns/1ps
`default_nettype none
module scdc_top
	import scdc_pkg::*;
#(
	parameter int OWN_BITS   = OWN_BITS_DEFAULT,
	parameter int FIFO_WORDS = FIFO_DEPTH
) (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic serial_master,
	input  wire logic first_in_chain,
	input  wire logic spi_mode,
	input  wire logic legacy_limit,
	input  wire logic completion_active_drive_option,
	input  wire logic completion_pipeline_option,
	input  wire logic config_clock_pin_in,
	output logic      config_clock_pin_out,
	output logic      config_clock_pin_oe,
	input  wire logic serial_din,
	input  wire logic flash_din,
	output logic      serial_dout,
	input  wire logic completion_in,
	output logic      completion_out,
	output logic      completion_oe,
	output logic      global_tristate_release,
	output logic      config_done,
	output logic      crc_error,
	output logic      chain_error
);
	// pins: clock, flash data, completion, straps
	logic [8:0] pin_raw;
	logic [8:0] pin_lvl;
	logic [8:0] pin_rise;
	logic [8:0] pin_fall;

	assign pin_raw = {legacy_limit, completion_pipeline_option,
		completion_active_drive_option, first_in_chain, serial_master,
		spi_mode, completion_in, flash_din, config_clock_pin_in};

	scdc_sync #(
		.WIDTH (9)
	) u_sync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.pin     (pin_raw),
		.level   (pin_lvl),
		.rise    (pin_rise),
		.fall    (pin_fall)
	);

	logic       flash_s;
	logic       done_s;
	logic       spi_s;
	logic       master_s;
	logic       first_s;
	logic       drive_s;
	logic       pipe_s;
	logic       legacy_s;
	logic       din_s;
	logic       din_meta;

	assign flash_s  = pin_lvl[1];
	assign done_s   = pin_lvl[2];
	assign spi_s    = pin_lvl[3];
	assign master_s = pin_lvl[4];
	assign first_s  = pin_lvl[5];
	assign drive_s  = pin_lvl[6];
	assign pipe_s   = pin_lvl[7];
	assign legacy_s = pin_lvl[8];

	// serial data gets its own pair so it lines up with the clock pair
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			din_meta <= 1'b0;
			din_s    <= 1'b0;
		end else begin
			din_meta <= serial_din;
			din_s    <= din_meta;
		end
	end

	// master clock divider
	logic [7:0]  div_cnt;
	logic        div_tick;
	logic        int_rise;
	logic        int_fall;
	logic        clk_run;
	logic        in_ready;

	assign div_tick = div_cnt == 8'(LINK_HALF_CYC - 1);
	// hold the clock low rather than overrun the fifo
	assign clk_run  = master_s && (config_clock_pin_out || in_ready);
	assign int_rise = div_tick && clk_run && !config_clock_pin_out;
	assign int_fall = div_tick && clk_run && config_clock_pin_out;

	scdc_state_e state;
	scdc_state_e next_state;

	logic        running;
	logic        clk_live;
	assign running = state != ST_DONE && state != ST_ERROR;
	assign clk_live = running || state == ST_DONE && config_clock_pin_out;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			div_cnt              <= 8'h00;
			config_clock_pin_out <= 1'b0;
			config_clock_pin_oe  <= 1'b0;
		end else begin
			config_clock_pin_oe <= master_s;
			if (!clk_run || !clk_live || div_tick) begin
				div_cnt <= 8'h00;
			end else begin
				div_cnt <= div_cnt + 8'h01;
			end
			if (div_tick && clk_run && clk_live) begin
				config_clock_pin_out <= !config_clock_pin_out;
			end
		end
	end

	// slaves follow the pin, the master its own divider
	logic rise_evt;
	logic fall_evt;
	assign rise_evt = master_s ? int_rise : pin_rise[0];
	assign fall_evt = master_s ? int_fall : pin_fall[0];

	// data fifo: every loaded bit passes through it
	logic src_bit;
	logic loading;
	logic push;
	logic out_valid;
	logic out_data;
	logic pop;
	logic fwd_slot;

	assign src_bit  = spi_s ? flash_s : din_s;
	assign loading  = state inside {ST_HEADER, ST_PASS, ST_OWN, ST_CHECK};
	assign push     = rise_evt && loading;
	assign fwd_slot = state == ST_PASS && fall_evt;
	assign pop      = out_valid && (state == ST_PASS ? fwd_slot : loading);

	scdc_fifo #(
		.WIDTH (1),
		.DEPTH (FIFO_WORDS)
	) u_fifo (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.in_valid  (push),
		.in_ready  (in_ready),
		.in_data   (src_bit),
		.out_valid (out_valid),
		.out_ready (pop),
		.out_data  (out_data)
	);

	// a slave cannot hold back its source, so a full fifo is fatal
	logic overflow;
	assign overflow = push && !in_ready && !master_s;

	// counters and shifters
	logic [31:0] bit_cnt;
	logic [31:0] pass_cnt;
	logic [15:0] crc;
	logic [15:0] crc_rx;
	logic        done_seen;
	logic [31:0] pass_limit;
	logic [31:0] hdr_next;
	logic        hdr_last;
	logic        own_last;
	logic        chk_last;
	logic [15:0] crc_rx_next;

	assign pass_limit  = legacy_s ? PASS_LIMIT_OLD : PASS_LIMIT_NEW;
	assign hdr_next    = {pass_cnt[30:0], out_data};
	assign crc_rx_next = {crc_rx[14:0], out_data};
	assign hdr_last    = bit_cnt == 32'(HDR_BITS - 1);
	assign own_last    = bit_cnt == 32'(OWN_BITS - 1);
	assign chk_last    = bit_cnt == 32'(CRC_BITS - 1);

	always_comb begin
		next_state = state;
		case (state)
			ST_HEADER: begin
				if (pop && hdr_last) begin
					if (hdr_next > pass_limit) begin
						next_state = ST_ERROR;
					end else if (hdr_next == 32'h0000_0000) begin
						next_state = ST_OWN;
					end else begin
						next_state = ST_PASS;
					end
				end
			end
			ST_PASS: begin
				// downstream data goes first, so own load ends the chain
				if (pop && pass_cnt == 32'h0000_0001) begin
					next_state = ST_OWN;
				end
			end
			ST_OWN: begin
				if (pop && own_last) begin
					next_state = ST_CHECK;
				end
			end
			ST_CHECK: begin
				if (pop && chk_last) begin
					next_state = (crc_rx_next == crc) ? ST_OUTREL : ST_ERROR;
				end
			end
			ST_OUTREL: begin
				if (rise_evt) begin
					next_state = ST_RELEASE;
				end
			end
			ST_RELEASE: begin
				if (rise_evt && done_s && (done_seen || !pipe_s)) begin
					next_state = ST_DONE;
				end
			end
			ST_DONE: next_state = ST_DONE;
			default: next_state = ST_ERROR;
		endcase
		if (overflow) begin
			next_state = ST_ERROR;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= ST_HEADER;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			bit_cnt  <= 32'h0000_0000;
			pass_cnt <= 32'h0000_0000;
			crc      <= CRC_INIT;
			crc_rx   <= 16'h0000;
		end else if (state != next_state) begin
			bit_cnt <= 32'h0000_0000;
			crc <= (state == ST_OWN && pop) ?
				scdc_crc_step(crc, out_data) : crc;
			if (state == ST_HEADER) begin
				pass_cnt <= hdr_next;
			end
		end else if (pop) begin
			bit_cnt <= bit_cnt + 32'h0000_0001;
			case (state)
				ST_HEADER: pass_cnt <= hdr_next;
				ST_PASS:   pass_cnt <= pass_cnt - 32'h0000_0001;
				ST_OWN:    crc <= scdc_crc_step(crc, out_data);
				ST_CHECK:  crc_rx <= crc_rx_next;
				default:   crc_rx <= crc_rx;
			endcase
		end
	end

	// pipeline option: completion must be seen on two rising edges
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			done_seen <= 1'b0;
		end else if (state != ST_RELEASE) begin
			done_seen <= 1'b0;
		end else if (rise_evt) begin
			done_seen <= done_s;
		end
	end

	// forwarded bit leaves on the falling edge, ready for the next rise
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			serial_dout <= 1'b0;
		end else if (pop && state == ST_PASS) begin
			serial_dout <= out_data;
		end
	end

	// completion pin: low while loading, released in startup
	logic release_ph;
	logic may_drive;
	logic next_done_oe;
	logic next_done_out;

	assign release_ph = state == ST_RELEASE || state == ST_DONE;
	// downstream devices never drive high, avoiding contention
	assign may_drive  = first_s && drive_s;
	assign next_done_oe  = release_ph ? may_drive : 1'b1;
	assign next_done_out = release_ph && may_drive;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			completion_oe           <= 1'b1;
			completion_out          <= 1'b0;
			global_tristate_release <= 1'b0;
			config_done             <= 1'b0;
			crc_error               <= 1'b0;
			chain_error             <= 1'b0;
		end else begin
			completion_oe  <= next_done_oe;
			completion_out <= next_done_out;
			if (next_state == ST_RELEASE) begin
				global_tristate_release <= 1'b1;
			end
			if (next_state == ST_DONE) begin
				config_done <= 1'b1;
			end
			if (state == ST_CHECK && next_state == ST_ERROR && !overflow) begin
				crc_error <= 1'b1;
			end
			if (next_state == ST_ERROR && state != ST_ERROR
				&& (state != ST_CHECK || overflow)) begin
				chain_error <= 1'b1;
			end
		end
	end
endmodule : scdc_top
`default_nettype wire

/* File: test/scdc_link_model.sv */
// scdc_link_model: upstream bit source and downstream sampler of the chain.
// assumes: makes a 200 ns link clock only inside frames; data moves on falls.
`timescale 1ns/1ps
`default_nettype none
module scdc_link_model (
	input  wire logic dut_clk_out,
	input  wire logic dut_clk_oe,
	input  wire logic dout,
	output wire logic link_clk,
	output logic      data
);
	logic drv_clk = 1'b0;
	logic q[$];
	logic got[$];
	// one clock rate for the whole chain
	assign link_clk = dut_clk_oe ? dut_clk_out : drv_clk;
	// past the stream the line toggles so stale bits never look valid
	always @(negedge link_clk)
		data <= (q.size() != 0) ? q.pop_front() : ~data;
	always @(posedge link_clk) begin
		#50;
		got.push_back(dout);
	end
	// edges sit 2 ns after a system clock edge, never on it
	task automatic run(input int n);
		#2;
		repeat (n) begin
			#100 drv_clk = 1'b1;
			#100 drv_clk = 1'b0;
		end
	endtask : run
	initial data = 1'b0;
endmodule : scdc_link_model
`default_nettype wire

/* File: test/scdc_properties.sv */
// scdc_properties: port-level checks of the serial chain loader.
// assumes: bound to scdc_top; straps only change while sys_rst is high.
`timescale 1ns/1ps
`default_nettype none
module scdc_properties
	import scdc_pkg::*;
#(
	parameter int OWN_BITS   = OWN_BITS_DEFAULT,
	parameter int FIFO_WORDS = FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic serial_master,
	input wire logic first_in_chain,
	input wire logic spi_mode,
	input wire logic legacy_limit,
	input wire logic completion_active_drive_option,
	input wire logic completion_pipeline_option,
	input wire logic config_clock_pin_in,
	input wire logic config_clock_pin_out,
	input wire logic config_clock_pin_oe,
	input wire logic serial_din,
	input wire logic flash_din,
	input wire logic serial_dout,
	input wire logic completion_in,
	input wire logic completion_out,
	input wire logic completion_oe,
	input wire logic global_tristate_release,
	input wire logic config_done,
	input wire logic crc_error,
	input wire logic chain_error
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	sequence s_pin_low;
		completion_oe && !completion_out;
	endsequence
	sequence s_clk_hold;
		config_clock_pin_out [*4];
	endsequence

	rel_first_a: assert property (!global_tristate_release |-> s_pin_low)
		else $error("completion pin let go before outputs");
	drive_first_a: assert property (completion_oe && completion_out
		|-> first_in_chain && completion_active_drive_option)
		else $error("completion driven high by a downstream device");
	release_off_a: assert property (global_tristate_release
		&& $past(global_tristate_release) && !first_in_chain
		&& !config_done |-> !completion_oe)
		else $error("completion pin not released");
	done_cause_a: assert property ($rose(config_done)
		|-> global_tristate_release && $past(completion_in, 3))
		else $error("done without completion high");
	done_bound_a: assert property (serial_master && completion_in
		&& global_tristate_release |-> ##[0:40] config_done)
		else $error("done late after completion high");
	crc_hold_a: assert property (crc_error
		|-> !global_tristate_release ##1 s_pin_low)
		else $error("startup after failed check");
	chain_stop_a: assert property (chain_error
		|-> !global_tristate_release && !config_done)
		else $error("startup after chain error");
	clk_owner_a: assert property (config_clock_pin_oe |-> serial_master)
		else $error("slave drives the clock pin");
	clk_half_a: assert property ($rose(config_clock_pin_out) |-> s_clk_hold)
		else $error("master clock high phase too short");
endmodule : scdc_properties

bind scdc_top scdc_properties #(
	.OWN_BITS   (OWN_BITS),
	.FIFO_WORDS (FIFO_WORDS)
) u_props (
	.clk                            (clk),
	.sys_rst                        (sys_rst),
	.serial_master                  (serial_master),
	.first_in_chain                 (first_in_chain),
	.spi_mode                       (spi_mode),
	.legacy_limit                   (legacy_limit),
	.completion_active_drive_option (completion_active_drive_option),
	.completion_pipeline_option     (completion_pipeline_option),
	.config_clock_pin_in            (config_clock_pin_in),
	.config_clock_pin_out           (config_clock_pin_out),
	.config_clock_pin_oe            (config_clock_pin_oe),
	.serial_din                     (serial_din),
	.flash_din                      (flash_din),
	.serial_dout                    (serial_dout),
	.completion_in                  (completion_in),
	.completion_out                 (completion_out),
	.completion_oe                  (completion_oe),
	.global_tristate_release        (global_tristate_release),
	.config_done                    (config_done),
	.crc_error                      (crc_error),
	.chain_error                    (chain_error)
);
`default_nettype wire

/* File: test/tb.sv */
// tb: self-checking bench of the serial chain loader of one device.
// assumes: scdc_link_model plays source and downstream; own bits set to 16.
`timescale 1ns/1ps
`default_nettype none
module tb
	import scdc_pkg::*;
;
	logic       clk = 1'b0;
	logic       sys_rst = 1'b1;
	logic [5:0] straps = 6'h00;
	logic       other_low = 1'b1;
	logic       clk_out, clk_oe, dout, c_out, c_oe;
	logic       out_rel, done, crc_err, ch_err;
	wire logic  link_clk, data;
	// shared open-drain wire with pull-up
	wire logic  c_in = c_oe ? c_out : !other_low;
	int         n_fail = 0;
	int         comparisons = 0;
	logic       down[$];

	always #12.5 clk = ~clk;

	scdc_top #(.OWN_BITS(16)) u_dut (
		.clk(clk), .sys_rst(sys_rst),
		.serial_master(straps[5]), .first_in_chain(straps[4]),
		.spi_mode(straps[3]), .legacy_limit(straps[2]),
		.completion_active_drive_option(straps[1]),
		.completion_pipeline_option(straps[0]),
		.config_clock_pin_in(link_clk), .config_clock_pin_out(clk_out),
		.config_clock_pin_oe(clk_oe),
		.serial_din(straps[3] ? ~data : data),
		.flash_din(straps[3] ? data : ~data), .serial_dout(dout),
		.completion_in(c_in), .completion_out(c_out), .completion_oe(c_oe),
		.global_tristate_release(out_rel), .config_done(done),
		.crc_error(crc_err), .chain_error(ch_err)
	);
	scdc_link_model u_src (
		.dut_clk_out(clk_out), .dut_clk_oe(clk_oe), .dout(dout),
		.link_clk(link_clk), .data(data)
	);

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic build(input logic [31:0] hdr, input int nd, input logic bad);
		logic [15:0] c;
		logic [31:0] oc;
		c = CRC_INIT;
		oc = 32'h5a3c_0000;
		for (int i = 15; i >= 0; i--)
			c = {c[14:0], 1'b0} ^ ((c[15] ^ oc[i + 16]) ? CRC_POLY : 16'h0);
		oc = {16'h5a3c, c ^ {15'h0, bad}};
		u_src.q.delete();
		u_src.got.delete();
		down.delete();
		for (int i = 31; i >= 0; i--)
			u_src.q.push_back(hdr[i]);
		for (int i = 0; i < nd; i++) begin
			down.push_back(i[0] ^ i[2]);
			u_src.q.push_back(i[0] ^ i[2]);
		end
		for (int i = 31; i >= 0; i--)
			u_src.q.push_back(oc[i]);
		u_src.data = u_src.q.pop_front();
	endtask : build

	task automatic do_reset(input logic [5:0] s);
		@(posedge clk);
		#2 sys_rst = 1'b1;
		straps = s;
		other_low = 1'b1;
		repeat (20) @(posedge clk);
		#2 sys_rst = 1'b0;
		repeat (4) @(posedge clk);
	endtask : do_reset

	task automatic t_slave(input logic bad);
		build(32'd8, 8, bad);
		do_reset(6'b000010);
		u_src.run(80);
		repeat (20) @(posedge clk);
		foreach (down[i])
			chk(u_src.got[33 + i], down[i]);
		chk(crc_err, bad);
		chk(out_rel, !bad);
		chk(c_oe, bad);
		chk(ch_err, 1'b0);
		chk(done, 1'b0);
		@(posedge clk);
		#2 other_low = 1'b0;
		@(posedge clk);
		u_src.run(3);
		repeat (10) @(posedge clk);
		chk(done, !bad);
		$display("slave load done, bad check %0d", bad);
	endtask : t_slave

	task automatic t_master();
		int n;
		build(32'd4, 4, 1'b0);
		do_reset(6'b111011);
		n = 0;
		while (done !== 1'b1 && n < 3000) begin
			@(posedge clk);
			n++;
		end
		chk(n < 3000, 1'b1);
		chk(clk_oe, 1'b1);
		foreach (down[i])
			chk(u_src.got[33 + i], down[i]);
		chk(c_oe & c_out, 1'b1);
		chk(out_rel, 1'b1);
		$display("master flash load done");
	endtask : t_master

	task automatic t_limit();
		logic [31:0] lim;
		for (int i = 0; i < 4; i++) begin
			lim = i[1] ? PASS_LIMIT_OLD : PASS_LIMIT_NEW;
			build(lim + i[0], 0, 1'b0);
			do_reset({3'b000, i[1], 2'b10});
			u_src.run(40);
			repeat (10) @(posedge clk);
			chk(ch_err, i[0]);
		end
		$display("pass limit done");
	endtask : t_limit

	task automatic wrap_up();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up

	initial begin
		t_slave(1'b0);
		t_slave(1'b1);
		t_master();
		t_limit();
		wrap_up();
	end
	// the run needs about 3,500 cycles; this is some seventeen times that
	initial begin
		#1_500_000;
		n_fail++;
		wrap_up();
	end
endmodule : tb
`default_nettype wire
